// ### rtl/mgmt_serial_slave.v
`include "phy_status_consts.vh"

// Serial management slave: samples MDC and MDIO through two flops each on
// CLK_SYS and walks preamble, start, op, addresses, turnaround and data.
module mgmt_serial_slave #(
  parameter [4:0] PHY_ADDR = 5'h01
) (
  input  wire        clk,        // System clock
  input  wire        reset,      // Synchronous reset, active high
  input  wire        mdc_pin,    // Raw management clock
  input  wire        mdio_in,    // Raw management data in
  output reg         mdio_out,   // Management data out
  output reg         mdio_oe,    // High while driving data
  output wire [4:0]  reg_addr,   // Register address of frame
  output reg         rd_req,     // Pulse: read data wanted
  input  wire [15:0] rd_data,    // Read data, valid with rd_req
  output reg         wr_req,     // Pulse: write with wr_data
  output reg  [15:0] wr_data     // Write data
);
  localparam [4:0] S_PRE = 5'b00001;
  localparam [4:0] S_HDR = 5'b00010;
  localparam [4:0] S_TA  = 5'b00100;
  localparam [4:0] S_RD  = 5'b01000;
  localparam [4:0] S_WR  = 5'b10000;

  reg  [1:0]  mdc_sync;
  reg  [1:0]  mdio_sync;
  reg         mdc_last;
  reg  [4:0]  state;
  reg  [5:0]  count;
  reg  [13:0] hdr;
  reg  [15:0] shift;
  reg         is_read;
  reg         mine;
  wire        rise = mdc_sync[1] & ~mdc_last;
  wire        fall = ~mdc_sync[1] & mdc_last;
  wire        bit_in = mdio_sync[1];
  // Header including the bit arriving now
  wire [13:0] hdr_next = {hdr[12:0], bit_in};

  assign reg_addr = hdr[4:0];

  always @(posedge clk)
  begin
    mdc_sync  <= {mdc_sync[0], mdc_pin};
    mdio_sync <= {mdio_sync[0], mdio_in};
    if (reset)
    begin
      mdc_last <= 1'b0;
      state    <= S_PRE;
      count    <= 6'd0;
      hdr      <= 14'h0000;
      shift    <= 16'h0000;
      is_read  <= 1'b0;
      mine     <= 1'b0;
      mdio_out <= 1'b0;
      mdio_oe  <= 1'b0;
      rd_req   <= 1'b0;
      wr_req   <= 1'b0;
      wr_data  <= 16'h0000;
    end
    else
    begin
      mdc_last <= mdc_sync[1];
      rd_req   <= 1'b0;
      wr_req   <= 1'b0;
      case (state)
        S_PRE:
        begin
          if (rise)
          begin
            if (bit_in)
              count <= (count == `MGMT_PREAMBLE_LEN) ? count : count + 6'd1;
            else if (count == `MGMT_PREAMBLE_LEN)
            begin
              // First zero of start pattern after full preamble
              state <= S_HDR;
              count <= 6'd0;
            end
            else
              count <= 6'd0;
          end
        end
        S_HDR:
        begin
          // Remaining start bit, op (2), phy addr (5), reg addr (5)
          if (rise)
          begin
            hdr   <= hdr_next;
            count <= count + 6'd1;
            if (count == `MGMT_HDR_LAST)
            begin
              is_read <= (hdr_next[11:10] == `MGMT_OP_READ);
              mine    <= (hdr_next[9:5] == PHY_ADDR) && (hdr_next[12] == 1'b1) &&
                         ((hdr_next[11:10] == `MGMT_OP_READ) ||
                          (hdr_next[11:10] == `MGMT_OP_WRITE));
              state   <= S_TA;
              count   <= 6'd0;
            end
          end
        end
        S_TA:
        begin
          if (rise)
          begin
            count <= count + 6'd1;
            if (count == 6'd0 && is_read && mine)
            begin
              // Fetch data; the read side effect happens here
              rd_req <= 1'b1;
            end
            if (count == `MGMT_TA_LAST)
            begin
              state <= is_read ? S_RD : S_WR;
              count <= 6'd0;
            end
          end
          if (rd_req)
            shift <= rd_data;
          if (fall && count == `MGMT_TA_LAST && is_read && mine)
          begin
            mdio_oe  <= 1'b1;
            mdio_out <= 1'b0;
          end
        end
        S_RD:
        begin
          if (fall)
          begin
            if (count == `MGMT_DATA_BITS)
            begin
              mdio_oe <= 1'b0;
              state   <= S_PRE;
              count   <= 6'd0;
            end
            else
            begin
              mdio_out <= shift[15];
              shift    <= {shift[14:0], 1'b0};
              count    <= count + 6'd1;
            end
          end
        end
        S_WR:
        begin
          if (rise)
          begin
            shift <= {shift[14:0], bit_in};
            count <= count + 6'd1;
            if (count == `MGMT_DATA_LAST)
            begin
              wr_data <= {shift[14:0], bit_in};
              wr_req  <= mine;
              state   <= S_PRE;
              count   <= 6'd0;
            end
          end
        end
        default:
        begin
          state <= S_PRE;
          count <= 6'd0;
        end
      endcase
    end
  end
endmodule // mgmt_serial_slave

// ### rtl/phy_status_consts.vh
`ifndef PHY_STATUS_CONSTS_VH
`define PHY_STATUS_CONSTS_VH

// Register addresses (5-bit management address space)
`define ADDR_PCS_LINK_STATUS      5'h13
`define ADDR_RX_SYMBOL_ERROR_CNT  5'h15
`define ADDR_IRQ_ENABLE_FLAGS     5'h1b
`define ADDR_CROSSOVER_CONTROL    5'h1c
`define ADDR_PHY_CTRL_RESOLVED    5'h1f

// pcs_link_status fields
`define BIT_LINK_GOOD_1000        2
`define BIT_LINK_GOOD_100         1

// irq_enable_and_flags source order, high bit first
`define SRC_JABBER                7
`define SRC_RX_ERROR              6
`define SRC_PAGE_RECEIVED         5
`define SRC_PARALLEL_FAULT        4
`define SRC_PARTNER_ACK           3
`define SRC_LINK_DOWN             2
`define SRC_REMOTE_FAULT          1
`define SRC_LINK_UP               0
`define IRQ_ENABLE_RESET          8'h00
`define IRQ_FLAGS_RESET           8'h00
`define LINK_STATUS_RESET         2'h0
`define RESOLVED_STATUS_RESET     6'h00

// crossover_control fields
`define BIT_FORCED_PAIR_MODE      7
`define BIT_CROSSOVER_OVERRIDE    6
`define CROSSOVER_RESET           16'h0000

// phy_ctrl_resolved_status fields
`define BIT_IRQ_POLARITY          14
`define BIT_JABBER_COUNT_EN       9
`define BIT_SPEED_1000            6
`define BIT_SPEED_100             5
`define BIT_SPEED_10              4
`define BIT_DUPLEX_FULL           3
`define BIT_MASTER                2
`define BIT_LINK_CHECK_FAIL       0
// Writable control bits 15:12, 9:7, 1; jabber enable resets to 1
`define PHY_CTRL_RW_MASK          16'hf382
`define PHY_CTRL_RESET            16'h0200

// Management frame shape
`define MGMT_PREAMBLE_LEN         6'd32
`define MGMT_HDR_LAST             6'd12
`define MGMT_TA_LAST              6'd1
`define MGMT_DATA_LAST            6'd15
`define MGMT_DATA_BITS            6'd16
`define MGMT_OP_READ              2'b10
`define MGMT_OP_WRITE             2'b01

`endif

// ### rtl/phy_status_interrupt_regs.v
`include "phy_status_consts.vh"

// Overview of operation
// - Read-only gigabit and 100M link-good flags
// - 16-bit symbol error counter, cleared on read
// - Upper byte: eight enables, reset zero
// - Lower byte: sticky event flags, cleared on read
// - Source order jabber down to link up
// - Polarity bit: 1 high, 0 low default
// - Override bit disables automatic pair selection
// - Forced mode picks MDI/MDI-X under override
// - Jabber counter enable, resets to one
// - One-hot resolved speed flags, zero at reset
// - Duplex flag: 1 full, 0 half
// - Master/slave flag: 1 master, 0 slave
module phy_status_interrupt_regs #(
  parameter [4:0] PHY_ADDR = 5'h01,
  parameter       CNT_W    = 16
) (
  input  wire        CLK_SYS,           // System clock, 10 MHz
  input  wire        RESET,             // Synchronous reset, active high
  input  wire        MDC,               // Management clock pin
  input  wire        MDIO_IN,           // Management data pin, input
  output wire        MDIO_OUT,          // Management data pin, output
  output wire        MDIO_OE,           // Management data pin, enable
  output wire        INT_PIN,           // Interrupt output
  input  wire        LINK_GOOD_1000,    // Gigabit link healthy
  input  wire        LINK_GOOD_100,     // 100M link healthy
  input  wire        RX_SYMBOL_ERROR,   // Pulse: frame with symbol error
  input  wire [7:0]  EVENT_IN,          // Pulses per interrupt source
  input  wire [2:0]  SPEED_RESOLVED,    // {1000,100,10} one-hot
  input  wire        DUPLEX_FULL,       // Full duplex resolved
  input  wire        MASTER_RESOLVED,   // Gigabit master
  input  wire        LINK_CHECK_FAIL,   // Link status check failed
  output reg         AUTO_CROSSOVER_EN, // Automatic pair selection on
  output reg         MDI_MODE,          // 1 MDI, 0 MDI-X pair use
  output wire        JABBER_COUNT_EN    // Jabber counter enabled
);
  wire [4:0]       addr;
  wire             rd_req;
  wire             wr_req;
  wire [15:0]      wr_data;
  reg  [15:0]      rd_mux;

  reg  [1:0]       link_s0;
  reg  [1:0]       link_s1;
  reg              symerr_s0;
  reg              symerr_s1;
  reg              symerr_d;
  reg  [7:0]       event_s0;
  reg  [7:0]       event_s1;
  reg  [7:0]       event_d;
  reg  [5:0]       stat_s0;
  reg  [5:0]       stat_s1;

  reg  [CNT_W-1:0] symerr_cnt;
  reg  [7:0]       irq_enable;
  reg  [7:0]       irq_flags;
  reg  [15:0]      crossover;
  reg  [15:0]      phy_ctrl;
  reg  [7:0]       next_flags;
  reg  [CNT_W-1:0] next_cnt;

  // Read strobe aimed at one register
  function read_hit;
    input       strobe;
    input [4:0] a;
    input [4:0] target;
    begin
      read_hit = strobe && (a == target);
    end
  endfunction

  wire       symerr_pulse = symerr_s1 & ~symerr_d;
  wire [7:0] event_pulse  = event_s1 & ~event_d;
  wire       rd_cnt       = read_hit(rd_req, addr, `ADDR_RX_SYMBOL_ERROR_CNT);
  wire       rd_irq       = read_hit(rd_req, addr, `ADDR_IRQ_ENABLE_FLAGS);
  wire       irq_active   = |(irq_flags & irq_enable);

  mgmt_serial_slave #(
    .PHY_ADDR (PHY_ADDR)
  ) u_mgmt (
    .clk      (CLK_SYS),
    .reset    (RESET),
    .mdc_pin  (MDC),
    .mdio_in  (MDIO_IN),
    .mdio_out (MDIO_OUT),
    .mdio_oe  (MDIO_OE),
    .reg_addr (addr),
    .rd_req   (rd_req),
    .rd_data  (rd_mux),
    .wr_req   (wr_req),
    .wr_data  (wr_data)
  );

  // Two-flop synchronisers on the event pins
  always @(posedge CLK_SYS)
  begin
    symerr_s0 <= RX_SYMBOL_ERROR;
    symerr_s1 <= symerr_s0;
    event_s0  <= EVENT_IN;
    event_s1  <= event_s0;
  end

  // Status synchronisers read zero during and after reset
  always @(posedge CLK_SYS)
  begin
    if (RESET)
    begin
      link_s0 <= `LINK_STATUS_RESET;
      link_s1 <= `LINK_STATUS_RESET;
      stat_s0 <= `RESOLVED_STATUS_RESET;
      stat_s1 <= `RESOLVED_STATUS_RESET;
    end
    else
    begin
      link_s0 <= {LINK_GOOD_1000, LINK_GOOD_100};
      link_s1 <= link_s0;
      stat_s0 <= {SPEED_RESOLVED, DUPLEX_FULL, MASTER_RESOLVED, LINK_CHECK_FAIL};
      stat_s1 <= stat_s0;
    end
  end

  // Saturating count; read clears, a same-cycle error counts as one
  always @*
  begin
    next_cnt = rd_cnt ? {CNT_W{1'b0}} : symerr_cnt;
    if (symerr_pulse && (next_cnt != {CNT_W{1'b1}}))
      next_cnt = next_cnt + {{(CNT_W-1){1'b0}}, 1'b1};
  end

  // Read clears flags, but an arriving event wins
  always @*
  begin
    next_flags = rd_irq ? 8'h00 : irq_flags;
    next_flags = next_flags | event_pulse;
  end

  always @(posedge CLK_SYS)
  begin
    if (RESET)
    begin
      symerr_d   <= 1'b0;
      event_d    <= 8'h00;
      symerr_cnt <= {CNT_W{1'b0}};
      irq_enable <= `IRQ_ENABLE_RESET;
      irq_flags  <= `IRQ_FLAGS_RESET;
      crossover  <= `CROSSOVER_RESET;
      phy_ctrl   <= `PHY_CTRL_RESET;
    end
    else
    begin
      symerr_d   <= symerr_s1;
      event_d    <= event_s1;
      symerr_cnt <= next_cnt;
      irq_flags  <= next_flags;
      if (wr_req)
      begin
        case (addr)
          `ADDR_IRQ_ENABLE_FLAGS:
            irq_enable <= wr_data[15:8];
          `ADDR_CROSSOVER_CONTROL:
            crossover <= wr_data;
          `ADDR_PHY_CTRL_RESOLVED:
            phy_ctrl <= wr_data & `PHY_CTRL_RW_MASK;
          default:
            irq_enable <= irq_enable;
        endcase
      end
    end
  end

  // Pair selection outputs
  always @(posedge CLK_SYS)
  begin
    if (RESET)
    begin
      AUTO_CROSSOVER_EN <= 1'b1;
      MDI_MODE          <= 1'b0;
    end
    else
    begin
      AUTO_CROSSOVER_EN <= ~crossover[`BIT_CROSSOVER_OVERRIDE];
      MDI_MODE          <= crossover[`BIT_CROSSOVER_OVERRIDE] &
                           crossover[`BIT_FORCED_PAIR_MODE];
    end
  end

  assign INT_PIN = phy_ctrl[`BIT_IRQ_POLARITY] ? irq_active : ~irq_active;
  assign JABBER_COUNT_EN = phy_ctrl[`BIT_JABBER_COUNT_EN];

  // Read mux; reserved bits read zero, except in crossover_control, which reads back all 16 bits as written
  always @*
  begin
    rd_mux = 16'h0000;
    case (addr)
      `ADDR_PCS_LINK_STATUS:
      begin
        rd_mux[`BIT_LINK_GOOD_1000] = link_s1[1];
        rd_mux[`BIT_LINK_GOOD_100]  = link_s1[0];
      end
      `ADDR_RX_SYMBOL_ERROR_CNT:
        rd_mux[CNT_W-1:0] = symerr_cnt;
      `ADDR_IRQ_ENABLE_FLAGS:
        rd_mux = {irq_enable, irq_flags};
      `ADDR_CROSSOVER_CONTROL:
        rd_mux = crossover;
      `ADDR_PHY_CTRL_RESOLVED:
      begin
        rd_mux = phy_ctrl;
        rd_mux[`BIT_SPEED_1000]      = stat_s1[5];
        rd_mux[`BIT_SPEED_100]       = stat_s1[4];
        rd_mux[`BIT_SPEED_10]        = stat_s1[3];
        rd_mux[`BIT_DUPLEX_FULL]     = stat_s1[2];
        rd_mux[`BIT_MASTER]          = stat_s1[1];
        rd_mux[`BIT_LINK_CHECK_FAIL] = stat_s1[0];
      end
      default:
        rd_mux = 16'h0000;
    endcase
  end
endmodule // phy_status_interrupt_regs

// ### tb/mgmt_station.sv
module mgmt_station (
  input wire logic clk,   // System clock
  input wire logic mdio,  // Resolved data line
  output logic     mdc,   // Mgmt clock
  output logic     mdo,   // Data driven
  output logic     mdo_en // Drive enable
);
  timeunit 1ns;
  timeprecision 1ns;
  localparam int HALF = 8;
  initial
  begin
    mdc = 1'b0;
    mdo = 1'b1;
    mdo_en = 1'b0;
  end
  task automatic cyc(input logic b, output logic s);
    mdc = 1'b0;
    mdo = b;
    repeat (HALF) @(negedge clk);
    s = mdio;
    mdc = 1'b1;
    repeat (HALF) @(negedge clk);
  endtask
  task automatic frame(input logic rd, input logic [4:0] ra, inout logic [15:0] d);
    logic [45:0] hdr;
    logic        s;
    hdr = {32'hffffffff, 2'b01, rd ? 2'b10 : 2'b01, 5'h01, ra};
    @(negedge clk);
    mdo_en = 1'b1;
    for (int i = 45; i >= 0; i--)
      cyc(hdr[i], s);
    // On reads, let go before the device's turnaround
    mdo_en = !rd;
    cyc(1'b1, s);
    cyc(1'b0, s);
    for (int i = 15; i >= 0; i--)
    begin
      cyc(d[i], s);
      if (rd)
        d[i] = s;
    end
    mdc = 1'b0;
    mdo_en = 1'b0;
    repeat (2 * HALF) @(negedge clk);
  endtask
endmodule // mgmt_station

// ### tb/phy_status_interrupt_regs_asserts.sv
module phy_status_interrupt_regs_asserts (
  input wire logic       CLK_SYS,           // Clock
  input wire logic       RESET,             // Reset
  input wire logic       MDC,               // Mgmt clock
  input wire logic       MDIO_OUT,          // Data out
  input wire logic       MDIO_OE,           // Drive enable
  input wire logic       INT_PIN,           // Interrupt
  input wire logic [7:0] EVENT_IN,          // Events
  input wire logic       AUTO_CROSSOVER_EN, // Auto pairs
  input wire logic       MDI_MODE,          // Pair mode
  input wire logic       JABBER_COUNT_EN    // Jabber enable
);
  timeunit 1ns;
  timeprecision 1ns;
  int       oe_cnt;
  int       quiet;
  logic       mdc_d;
  logic [7:0] ev_d;
  // Cycles since the last MDC or event edge
  always @(posedge CLK_SYS)
  begin
    oe_cnt <= MDIO_OE ? oe_cnt + 1 : 0;
    quiet  <= (MDC != mdc_d || EVENT_IN != ev_d) ? 0 : quiet + 1;
    mdc_d  <= MDC;
    ev_d   <= EVENT_IN;
  end
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (RESET);
  property p_rst_cfg;
    disable iff (1'b0) RESET |=> AUTO_CROSSOVER_EN && !MDI_MODE && JABBER_COUNT_EN && !MDIO_OE;
  endproperty
  a_rst_cfg: assert property (p_rst_cfg)
    else $error("config outputs wrong after reset");
  property p_rst_int;
    disable iff (1'b0) RESET |=> INT_PIN;
  endproperty
  a_rst_int: assert property (p_rst_int)
    else $error("interrupt not idle high after reset");
  property p_mdi_forced;
    MDI_MODE |-> !AUTO_CROSSOVER_EN;
  endproperty
  a_mdi_forced: assert property (p_mdi_forced)
    else $error("pair mode forced without override");
  property p_ta_zero;
    $rose(MDIO_OE) |-> !MDIO_OUT;
  endproperty
  a_ta_zero: assert property (p_ta_zero)
    else $error("turnaround not driven low");
  property p_out_low;
    MDIO_OE && $changed(MDIO_OUT) |-> !MDC;
  endproperty
  a_out_low: assert property (p_out_low)
    else $error("read data changed while MDC high");
  // 17 bit times of 16 cycles with the bench MDC
  property p_oe_len;
    $fell(MDIO_OE) |-> oe_cnt >= 268 && oe_cnt <= 276;
  endproperty
  a_oe_len: assert property (p_oe_len)
    else $error("read drive length wrong");
  property p_cfg_quiet;
    MDIO_OE |=> $stable({AUTO_CROSSOVER_EN, MDI_MODE, JABBER_COUNT_EN});
  endproperty
  a_cfg_quiet: assert property (p_cfg_quiet)
    else $error("config changed during a read");
  property p_int_cause;
    $changed(INT_PIN) |-> quiet < 8;
  endproperty
  a_int_cause: assert property (p_int_cause)
    else $error("interrupt changed without a cause");
  c_int: cover property ($fell(INT_PIN));
  c_read: cover property ($rose(MDIO_OE));
  c_forced: cover property ($rose(MDI_MODE));
endmodule // phy_status_interrupt_regs_asserts

// ### tb/phy_status_interrupt_regs_tb_top.sv
`define CHK(n, e, a) begin comparisons++; if ((a) !== (e)) begin err_count++; \
  $display("wrong value %s exp %h got %h", n, e, a); end end
module phy_status_interrupt_regs_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic       clk_sys = 1'b0;
  logic       reset = 1'b1;
  logic       link_1000 = 1'b0;
  logic       link_100 = 1'b0;
  logic       rx_err = 1'b0;
  logic [7:0] event_in = 8'h00;
  logic [2:0] speed = 3'h0;
  logic       duplex = 1'b0;
  logic       master = 1'b0;
  logic       link_fail = 1'b0;
  logic [15:0] xv [3] = '{16'h00c0, 16'h0040, 16'h0080};
  logic [1:0]  xe [3] = '{2'b01, 2'b00, 2'b10};
  wire mdc, mdo, mdo_en, mdio_out, mdio_oe, int_pin, auto_x, mdi_mode, jab_en;
  // Pull-up holds the line high when nobody drives
  wire mdio = mdio_oe ? mdio_out : (mdo_en ? mdo : 1'b1);
  int err_count = 0;
  int comparisons = 0;
  always #50 clk_sys = ~clk_sys;
  phy_status_interrupt_regs i_phy_status_interrupt_regs (
    .CLK_SYS(clk_sys), .RESET(reset), .MDC(mdc), .MDIO_IN(mdio),
    .MDIO_OUT(mdio_out), .MDIO_OE(mdio_oe), .INT_PIN(int_pin),
    .LINK_GOOD_1000(link_1000), .LINK_GOOD_100(link_100), .RX_SYMBOL_ERROR(rx_err),
    .EVENT_IN(event_in), .SPEED_RESOLVED(speed), .DUPLEX_FULL(duplex),
    .MASTER_RESOLVED(master), .LINK_CHECK_FAIL(link_fail),
    .AUTO_CROSSOVER_EN(auto_x), .MDI_MODE(mdi_mode), .JABBER_COUNT_EN(jab_en));
  mgmt_station i_mgmt_station (.clk(clk_sys), .mdio(mdio), .mdc(mdc), .mdo(mdo),
    .mdo_en(mdo_en));
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    logic [15:0] v;
    v = d;
    i_mgmt_station.frame(1'b0, a, v);
  endtask
  task automatic rd_chk(input logic [4:0] a, input logic [15:0] e, input string n);
    logic [15:0] v;
    v = 16'h0000;
    i_mgmt_station.frame(1'b1, a, v);
    `CHK(n, e, v)
  endtask
  task automatic pulse_ev(input int k);
    @(negedge clk_sys);
    event_in[k] = 1'b1;
    repeat (2) @(negedge clk_sys);
    event_in[k] = 1'b0;
    repeat (8) @(negedge clk_sys);
  endtask
  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial
  begin
    repeat (80000) @(posedge clk_sys);
    err_count++;
    wrap_up();
  end
  initial
  begin
    repeat (16) @(negedge clk_sys);
    reset = 1'b0;
    @(negedge clk_sys);
    `CHK("int", 1'b1, int_pin)
    `CHK("cfg", 3'b101, {auto_x, mdi_mode, jab_en})
    rd_chk(5'h1b, 16'h0000, "irq");
    rd_chk(5'h1c, 16'h0000, "xover");
    rd_chk(5'h1f, 16'h0200, "ctrl");
    $display("test reset done");
    for (int i = 0; i < 3; i++)
    begin
      speed = 3'b001 << i;
      link_1000 = (i == 2);
      link_100 = (i == 1);
      duplex = i[0];
      master = i[1];
      link_fail = i[0];
      rd_chk(5'h13, {13'h0, link_1000, link_100, 1'b0}, "link");
      rd_chk(5'h1f, {6'h0, 1'b1, 2'h0, speed, duplex, master, 1'b0, link_fail}, "st");
    end
    $display("test status done");
    repeat (5)
    begin
      @(negedge clk_sys);
      rx_err = 1'b1;
      repeat (4) @(negedge clk_sys);
      rx_err = 1'b0;
      repeat (4) @(negedge clk_sys);
    end
    rd_chk(5'h15, 16'h0005, "count");
    rd_chk(5'h15, 16'h0000, "count");
    $display("test counter done");
    for (int k = 0; k < 8; k++)
    begin
      wr(5'h1b, 16'h0100 << k);
      pulse_ev((k + 1) % 8);
      `CHK("int", 1'b1, int_pin)
      pulse_ev(k);
      `CHK("int", 1'b0, int_pin)
      rd_chk(5'h1b, (16'h0101 << k) | (16'h0001 << ((k + 1) % 8)), "flags");
      `CHK("int", 1'b1, int_pin)
      rd_chk(5'h1b, 16'h0100 << k, "flags");
    end
    $display("test interrupt done");
    wr(5'h1f, 16'h4000);
    `CHK("int", 1'b0, int_pin)
    `CHK("jabber", 1'b0, jab_en)
    rd_chk(5'h1f, 16'h4044, "ctrl");
    pulse_ev(7);
    `CHK("int", 1'b1, int_pin)
    rd_chk(5'h1b, 16'h8080, "flags");
    $display("test polarity done");
    for (int j = 0; j < 3; j++)
    begin
      wr(5'h1c, xv[j]);
      `CHK("xover", xe[j], {auto_x, mdi_mode})
    end
    rd_chk(5'h1c, 16'h0080, "xover");
    rd_chk(5'h10, 16'h0000, "unmapped");
    wr(5'h1f, 16'hffff);
    rd_chk(5'h1f, 16'hf3c6, "ctrl");
    wr(5'h15, 16'h1234);
    rd_chk(5'h15, 16'h0000, "count");
    $display("test crossover done");
    wrap_up();
  end
endmodule // phy_status_interrupt_regs_tb_top
bind phy_status_interrupt_regs phy_status_interrupt_regs_asserts i_asserts (
  .CLK_SYS(CLK_SYS), .RESET(RESET), .MDC(MDC), .MDIO_OUT(MDIO_OUT), .MDIO_OE(MDIO_OE),
  .INT_PIN(INT_PIN), .EVENT_IN(EVENT_IN), .AUTO_CROSSOVER_EN(AUTO_CROSSOVER_EN),
  .MDI_MODE(MDI_MODE), .JABBER_COUNT_EN(JABBER_COUNT_EN));
